// file: cssac_top.v
// Purpose: card supply activation and deactivation sequencer with chip power-off
// Assumes: pins are asynchronous; register port on this clock; 10 MHz clock
// Notes:   a sequence step is a fixed number of clocks; the timer counts a
//          divided 32768 Hz enable, so the interval is coarse by one tick
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "cssac_defines.vh"
module cssac_top #(
  parameter TICK_DIV   = `CSSAC_TICK_DIV,
  parameter STEP_CYCLES = `CSSAC_STEP_CYCLES
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [15:0] regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  input  wire        supplyStablePin,
  input  wire        cardEventPin,
  input  wire        coreFaultPin,
  input  wire        onOffSwitchPin,
  input  wire        busPowerPin,
  output reg  [1:0]  supplyLevel,
  output reg         cardResetOut,
  output reg         cardClockEn,
  output reg         cardIoEn,
  output reg         coreSupplyEn,
  output wire        irq
);
  localparam ST_OFF     = 3'd0;
  localparam ST_POWERUP = 3'd1;
  localparam ST_CLOCK   = 3'd2;
  localparam ST_ACTIVE  = 3'd3;
  localparam ST_DN_RST  = 3'd4;
  localparam ST_DN_CLK  = 3'd5;
  localparam ST_DN_IO   = 3'd6;
  localparam ST_DN_VCC  = 3'd7;

  // reset release
  reg rstA_ff;
  reg rstB_ff;
  wire rstN = rstB_ff;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstA_ff <= 1'b0;
      rstB_ff <= 1'b0;
    end else begin
      rstA_ff <= 1'b1;
      rstB_ff <= rstA_ff;
    end
  end

  wire [4:0] pinSync;
  cssac_sync #(
    .WIDTH (5)
  ) u_sync (
    .clock   (clock),
    .rstN    (rstN),
    .asyncIn ({busPowerPin, onOffSwitchPin, coreFaultPin, cardEventPin, supplyStablePin}),
    .syncOut (pinSync)
  );
  wire stableSync = pinSync[0];
  wire cardEvtSync = pinSync[1];
  wire faultSync = pinSync[2];
  wire switchSync = pinSync[3];
  wire busPwrSync = pinSync[4];

  reg        cardEvtDly_ff;
  reg        faultDly_ff;
  reg  [1:0] select_ff;
  reg        faultFlag_ff;
  reg        readyStart_ff;
  reg        powerOff_ff;
  reg  [7:0] timerReg_ff;
  reg  [3:0] status_ff;
  reg  [3:0] mask_ff;
  reg  [2:0] state_ff;
  reg  [3:0] ticks_ff;
  reg        timerRun_ff;
  reg [15:0] divCnt_ff;
  reg [15:0] stepCnt_ff;
  reg        stableSeen_ff;

  wire cardEvtPulse = cardEvtSync & ~cardEvtDly_ff;
  wire faultPulse = faultSync & ~faultDly_ff;
  wire ctlWrite = regWrite && (regAddr == `CSSAC_ADDR_CTL);
  wire [1:0] wrSel = regWrData[`CSSAC_CTL_SEL_HI:`CSSAC_CTL_SEL_LO];
  wire startReq = ctlWrite && (wrSel != 2'b00) && (state_ff == ST_OFF);
  wire [3:0] interval = timerReg_ff[3:0];
  wire tick = (divCnt_ff == 16'h0000);
  wire stepDone = (stepCnt_ff == 16'h0000);
  wire running = (state_ff == ST_POWERUP) || (state_ff == ST_CLOCK) || (state_ff == ST_ACTIVE);
  wire timerExpire = timerRun_ff && tick && (ticks_ff == 4'h1);
  wire stableFail = timerExpire && !stableSync;
  wire stableLoss = stableSeen_ff && !stableSync && running;
  wire deact = running && (cardEvtPulse || stableLoss || faultPulse || stableFail
               || (!readyStart_ff && timerExpire)
               || (select_ff == 2'b00));

  // 32768 Hz tick divider
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      divCnt_ff <= 16'h0000;
    end else if (tick) begin
      divCnt_ff <= TICK_DIV[15:0] - 16'h0001;
    end else begin
      divCnt_ff <= divCnt_ff - 16'h0001;
    end
  end

  // stable-supply timer
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ticks_ff <= 4'h0;
      timerRun_ff <= 1'b0;
    end else if (startReq) begin
      ticks_ff <= interval;
      timerRun_ff <= (interval != 4'h0);
    end else if (deact || timerExpire) begin
      timerRun_ff <= 1'b0;
    end else if (timerRun_ff && tick) begin
      ticks_ff <= ticks_ff - 4'h1;
    end
  end

  // control register and edge history
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      select_ff <= 2'b00;
      faultFlag_ff <= 1'b1;
      readyStart_ff <= 1'b0;
      powerOff_ff <= 1'b0;
      timerReg_ff <= `CSSAC_TMR_RESET;
      cardEvtDly_ff <= 1'b0;
      faultDly_ff <= 1'b0;
    end else begin
      cardEvtDly_ff <= cardEvtSync;
      faultDly_ff <= faultSync;
      if (regWrite && (regAddr == `CSSAC_ADDR_TMR)) begin
        timerReg_ff <= regWrData;
      end
      if (ctlWrite) begin
        select_ff <= wrSel;
        readyStart_ff <= regWrData[`CSSAC_CTL_READY_START];
        powerOff_ff <= regWrData[`CSSAC_CTL_PWROFF];
        faultFlag_ff <= regWrData[`CSSAC_CTL_FAULT] | faultFlag_ff;
      end
      if (faultPulse) begin
        faultFlag_ff <= 1'b0;
        select_ff <= 2'b00;
      end else if (deact || stableFail) begin
        select_ff <= 2'b00;
      end
      if (powerOff_ff && !coreSupplyEn) begin
        powerOff_ff <= 1'b0;
      end
    end
  end

  // activation and deactivation sequencer
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_ff <= ST_OFF;
      stepCnt_ff <= 16'h0000;
      stableSeen_ff <= 1'b0;
      supplyLevel <= 2'b00;
      cardResetOut <= 1'b0;
      cardClockEn <= 1'b0;
      cardIoEn <= 1'b0;
    end else begin
      if (!stepDone) begin
        stepCnt_ff <= stepCnt_ff - 16'h0001;
      end
      if (deact) begin
        state_ff <= ST_DN_RST;
        stableSeen_ff <= 1'b0;
        cardResetOut <= 1'b0;
        stepCnt_ff <= STEP_CYCLES[15:0];
      end else begin
        case (state_ff)
          ST_OFF: begin
            if (startReq) begin
              supplyLevel <= wrSel;
              state_ff <= ST_POWERUP;
            end
          end
          ST_POWERUP: begin
            // ready_start lets a settled supply proceed before the timer ends
            if (stableSync && (readyStart_ff || timerExpire)) begin
              state_ff <= ST_CLOCK;
              stableSeen_ff <= 1'b1;
              cardIoEn <= 1'b1;
              cardClockEn <= 1'b1;
              stepCnt_ff <= STEP_CYCLES[15:0];
            end
          end
          ST_CLOCK: begin
            if (stepDone) begin
              cardResetOut <= 1'b1;
              state_ff <= ST_ACTIVE;
            end
          end
          ST_ACTIVE: begin
            state_ff <= ST_ACTIVE;
          end
          ST_DN_RST: begin
            if (stepDone) begin
              cardClockEn <= 1'b0;
              state_ff <= ST_DN_CLK;
              stepCnt_ff <= STEP_CYCLES[15:0];
            end
          end
          ST_DN_CLK: begin
            if (stepDone) begin
              cardIoEn <= 1'b0;
              state_ff <= ST_DN_IO;
              stepCnt_ff <= STEP_CYCLES[15:0];
            end
          end
          ST_DN_IO: begin
            if (stepDone) begin
              supplyLevel <= 2'b00;
              state_ff <= ST_DN_VCC;
            end
          end
          default: begin
            state_ff <= ST_OFF;
          end
        endcase
      end
    end
  end

  // chip power-off: defer while bus power is present
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      coreSupplyEn <= 1'b1;
    end else if (!coreSupplyEn) begin
      if (switchSync || busPwrSync) begin
        coreSupplyEn <= 1'b1;
      end
    end else if (powerOff_ff && !busPwrSync) begin
      coreSupplyEn <= 1'b0;
    end
  end

  // sticky event status, write one to clear, set wins
  // a supply that is not stable at the interval end is also reported as a card event
  wire [3:0] events = {deact, faultPulse, stableFail, cardEvtPulse | stableFail};
  wire statusWrite = regWrite && (regAddr == `CSSAC_ADDR_IRQ);
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      status_ff <= 4'h0;
      mask_ff <= 4'h0;
    end else begin
      status_ff <= (status_ff & ~(statusWrite ? regWrData[3:0] : 4'h0)) | events;
      if (regWrite && (regAddr == `CSSAC_ADDR_MASK)) begin
        mask_ff <= regWrData[3:0];
      end
    end
  end
  assign irq = |(status_ff & mask_ff);

  // read port, data one cycle after the strobe
  reg [7:0] rdMux;
  always @* begin
    rdMux = 8'h00;
    case (regAddr)
      `CSSAC_ADDR_CTL: rdMux = {select_ff, faultFlag_ff, readyStart_ff,
                                stableSync, 2'b00, powerOff_ff};
      `CSSAC_ADDR_TMR: rdMux = timerReg_ff;
      `CSSAC_ADDR_IRQ: rdMux = {4'h0, status_ff};
      `CSSAC_ADDR_MASK: rdMux = {4'h0, mask_ff};
      default: rdMux = 8'h00;
    endcase
  end
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

// file: cssac_defines.vh
// Purpose: constants for the card supply activation control block
// Assumes: 10 MHz clock, 32768 Hz timer tick, byte-wide register port
// Notes:   offsets are byte addresses on the plain register port
// How it works
// - nonzero supply_select write starts activation
// - card event or stable loss deactivates
// - lines shut down before supply removed
// - core fault clears flag and select
// - ready_start set: activate when stable
// - ready_start clear: deactivate on timer expiry
// - read-only supply_stable status bit
// - chip_power_off bit requests chip power-off
// - power restored by switch or bus power
// - bus power present defers core shutdown
// - timer starts on nonzero select write
// - stable must hold at interval end
// - unstable at end: flag, deactivate, clear
// - timer register resets to 0x0F
// - interval is field times 32768Hz period
// - field zero disables timeout entirely
`ifndef CSSAC_DEFINES_VH
`define CSSAC_DEFINES_VH
`define CSSAC_ADDR_CTL      16'hfe03
`define CSSAC_ADDR_TMR      16'hfe04
`define CSSAC_ADDR_IRQ      16'hfe08
`define CSSAC_ADDR_MASK     16'hfe09
`define CSSAC_CTL_SEL_HI    7
`define CSSAC_CTL_SEL_LO    6
`define CSSAC_CTL_FAULT     5
`define CSSAC_CTL_READY_START     4
`define CSSAC_CTL_STABLE    3
`define CSSAC_CTL_PWROFF    0
`define CSSAC_TMR_RESET     8'h0f
`define CSSAC_IRQ_CARD      0
`define CSSAC_IRQ_TIMER     1
`define CSSAC_IRQ_FAULT     2
`define CSSAC_IRQ_ACTIVE    3
`define CSSAC_CLK_HZ        10000000
`define CSSAC_TICK_HZ       32768
`define CSSAC_TICK_DIV      (`CSSAC_CLK_HZ / `CSSAC_TICK_HZ)
`define CSSAC_STEP_CYCLES   4
`endif

// file: cssac_sync.v
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module cssac_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rstN,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= {WIDTH{1'b0}};
      stage2_ff <= {WIDTH{1'b0}};
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule

// file: cssac_supply_model.sv
// Purpose: card supply regulator stand-in
// Assumes: stable rises delay+1 clocks after a nonzero level is applied
// Notes:   delay 8'hff never settles; drop forces a supply loss
`timescale 1ns/10ps
module cssac_supply_model (
  input  wire       clock,
  input  wire [1:0] level,
  input  wire [7:0] delay,
  input  wire       drop,
  output reg        stable = 1'b0
);
  reg [7:0] cnt_ff = 8'h00;
  always @(posedge clock) begin
    if (level == 2'b00 || drop) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
    stable <= level != 2'b00 && !drop && delay != 8'hff && cnt_ff >= delay;
  end
endmodule

// file: cssac_checker.sv
// Purpose: port-level assertions for the card supply sequencer
// Assumes: pins pass a two flop synchroniser
// Notes:   windows allow for the synchroniser latency
`timescale 1ns/10ps
`include "cssac_defines.vh"
module cssac_checker #(parameter TICK_DIV = 4, parameter STEP_CYCLES = 4) (
  input wire        clock,
  input wire        reset_n,
  input wire [15:0] regAddr,
  input wire [7:0]  regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regRdData,
  input wire        supplyStablePin,
  input wire        cardEventPin,
  input wire        coreFaultPin,
  input wire        busPowerPin,
  input wire [1:0]  supplyLevel,
  input wire        cardResetOut,
  input wire        cardClockEn,
  input wire        cardIoEn,
  input wire        coreSupplyEn
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_linesOff;
    !cardResetOut && !cardClockEn && !cardIoEn;
  endsequence
  sequence s_busHeld;
    busPowerPin [*8];
  endsequence
  a_sel_starts: assert property (regWrite && regAddr == `CSSAC_ADDR_CTL && regWrData[7:6] != 0
    && supplyLevel == 0 && !cardResetOut && !cardEventPin && !coreFaultPin
    |-> ##[1:2] supplyLevel != 0) else $error("select write did not start");
  a_supply_last: assert property ($changed(supplyLevel) && supplyLevel == 0
    |-> s_linesOff and $past(cardIoEn) == 0) else $error("supply cut early");
  a_lines_supply: assert property (cardResetOut || cardClockEn || cardIoEn
    |-> supplyLevel != 0) else $error("lines live without supply");
  a_reset_last: assert property ($rose(cardResetOut)
    |-> cardClockEn && cardIoEn && $past(cardClockEn, 4)) else $error("reset early");
  a_read_stands: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside slot");
  a_fault_deact: assert property ($rose(coreFaultPin) && cardResetOut
    |-> ##[1:8] !cardResetOut) else $error("fault ignored");
  a_event_deact: assert property ($rose(cardEventPin) && cardResetOut
    |-> ##[1:8] !cardResetOut) else $error("card event ignored");
  a_loss_deact: assert property ($fell(supplyStablePin) && cardResetOut
    |-> ##[1:8] !cardResetOut) else $error("supply loss ignored");
  a_bus_keeps: assert property (s_busHeld |-> coreSupplyEn)
    else $error("core off with bus power");
endmodule
bind cssac_top cssac_checker #(.TICK_DIV(TICK_DIV), .STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .supplyStablePin(supplyStablePin), .cardEventPin(cardEventPin),
  .coreFaultPin(coreFaultPin), .busPowerPin(busPowerPin), .supplyLevel(supplyLevel),
  .cardResetOut(cardResetOut), .cardClockEn(cardClockEn), .cardIoEn(cardIoEn),
  .coreSupplyEn(coreSupplyEn));

// file: tb_card_supply_activation_control.sv
// Purpose: self-checking bench for the card supply sequencer
// Assumes: tick divider shortened to 4 clocks
// Notes:   every wait is bounded, a stuck sequence shows as a mismatch
`timescale 1ns/10ps
`include "cssac_defines.vh"
module tb_card_supply_activation_control;
  reg         clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  reg         cardEventPin = 1'b0, coreFaultPin = 1'b0, onOffSwitchPin = 1'b0;
  reg         busPowerPin = 1'b0, drop = 1'b0;
  reg  [15:0] regAddr = 16'h0000;
  reg  [7:0]  regWrData = 8'h00, dly = 8'h0a, mSt;
  wire [7:0]  regRdData;
  wire [1:0]  supplyLevel;
  wire        stable, cardResetOut, cardClockEn, cardIoEn, coreSupplyEn, irq;
  integer     n_fail = 0, comparisons = 0, cyc = 0, seed = 24121, i, k, r;
  cssac_top #(.TICK_DIV(4), .STEP_CYCLES(4)) u_dut (.clock(clock), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .supplyStablePin(stable), .cardEventPin(cardEventPin),
    .coreFaultPin(coreFaultPin), .onOffSwitchPin(onOffSwitchPin),
    .busPowerPin(busPowerPin), .supplyLevel(supplyLevel), .cardResetOut(cardResetOut),
    .cardClockEn(cardClockEn), .cardIoEn(cardIoEn), .coreSupplyEn(coreSupplyEn), .irq(irq));
  cssac_supply_model u_sup (.clock(clock), .level(supplyLevel), .delay(dly), .drop(drop),
    .stable(stable));
  initial forever #50 clock = ~clock;
  task end_sim;
    begin
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e, input string nm);
    begin
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chk(nm, regRdData, e);
    end
  endtask
  function sig(input integer s);
    sig = s == 0 ? cardResetOut : s == 1 ? supplyLevel == 2'b00 : coreSupplyEn;
  endfunction
  task waitOn(input integer s, input v, input string nm);
    begin
      for (i = 0; i < 400 && sig(s) !== v; i = i + 1) begin
        @(posedge clock);
        #1;
      end
      chk(nm, {7'h00, sig(s)}, {7'h00, v});
    end
  endtask
  task pulse(input integer p);
    begin
      @(posedge clock);
      if (p == 0) cardEventPin <= 1'b1;
      else coreFaultPin <= 1'b1;
      repeat (4) @(posedge clock);
      cardEventPin <= 1'b0;
      coreFaultPin <= 1'b0;
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk("core", {7'h00, coreSupplyEn}, 8'h01);
    rd(`CSSAC_ADDR_CTL, 8'h20, "ctl");
    rd(`CSSAC_ADDR_TMR, 8'h0f, "tmr");
    rd(16'hfe0a, 8'h00, "unmapped");
    r = $random(seed);
    wr(`CSSAC_ADDR_TMR, {4'h0, r[3:0]});
    rd(`CSSAC_ADDR_TMR, {4'h0, r[3:0]}, "tmr");
    wr(`CSSAC_ADDR_TMR, 8'h0f);
    for (k = 1; k < 4; k = k + 1) begin
      wr(`CSSAC_ADDR_MASK, 8'h0f);
      wr(`CSSAC_ADDR_CTL, {k[1:0], 6'h30});
      waitOn(0, 1'b1, "rst");
      chk("lvl", {6'h00, supplyLevel}, k[7:0]);
      rd(`CSSAC_ADDR_CTL, {k[1:0], 6'h38}, "ctl");
      pulse(0);
      waitOn(1, 1'b1, "off");
      mSt = 8'h09;
      rd(`CSSAC_ADDR_IRQ, mSt, "sts");
      chk("irq", {7'h00, irq}, 8'h01);
      wr(`CSSAC_ADDR_MASK, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(`CSSAC_ADDR_IRQ, 8'h0f);
      rd(`CSSAC_ADDR_IRQ, 8'h00, "sts");
      wr(`CSSAC_ADDR_CTL, 8'h20);
    end
    dly <= 8'hff;
    wr(`CSSAC_ADDR_TMR, 8'h02);
    wr(`CSSAC_ADDR_CTL, 8'h60);
    waitOn(1, 1'b1, "off");
    rd(`CSSAC_ADDR_IRQ, 8'h0b, "sts");
    rd(`CSSAC_ADDR_CTL, 8'h20, "ctl");
    wr(`CSSAC_ADDR_IRQ, 8'h0f);
    dly <= 8'h0a;
    wr(`CSSAC_ADDR_TMR, 8'h0f);
    wr(`CSSAC_ADDR_CTL, 8'h60);
    repeat (30) @(posedge clock);
    chk("rst", {7'h00, cardResetOut}, 8'h00);
    chk("lvl", {6'h00, supplyLevel}, 8'h01);
    waitOn(1, 1'b1, "off");
    rd(`CSSAC_ADDR_IRQ, 8'h08, "sts");
    wr(`CSSAC_ADDR_IRQ, 8'h0f);
    wr(`CSSAC_ADDR_CTL, 8'h70);
    waitOn(0, 1'b1, "rst");
    drop <= 1'b1;
    waitOn(1, 1'b1, "off");
    drop <= 1'b0;
    rd(`CSSAC_ADDR_IRQ, 8'h08, "sts");
    wr(`CSSAC_ADDR_IRQ, 8'h0f);
    wr(`CSSAC_ADDR_CTL, 8'h70);
    waitOn(0, 1'b1, "rst");
    pulse(1);
    waitOn(1, 1'b1, "off");
    // let the stable level fall through the regulator and the synchroniser
    repeat (4) @(posedge clock);
    rd(`CSSAC_ADDR_CTL, 8'h10, "ctl");
    rd(`CSSAC_ADDR_IRQ, 8'h0c, "sts");
    wr(`CSSAC_ADDR_IRQ, 8'h0f);
    dly <= 8'hff;
    wr(`CSSAC_ADDR_TMR, 8'h00);
    wr(`CSSAC_ADDR_CTL, 8'h60);
    repeat (100) @(posedge clock);
    chk("lvl", {6'h00, supplyLevel}, 8'h01);
    wr(`CSSAC_ADDR_CTL, 8'h20);
    waitOn(1, 1'b1, "off");
    busPowerPin <= 1'b1;
    wr(`CSSAC_ADDR_CTL, 8'h21);
    repeat (20) @(posedge clock);
    chk("core", {7'h00, coreSupplyEn}, 8'h01);
    busPowerPin <= 1'b0;
    waitOn(2, 1'b0, "core");
    @(posedge clock);
    onOffSwitchPin <= 1'b1;
    waitOn(2, 1'b1, "core");
    @(posedge clock);
    onOffSwitchPin <= 1'b0;
    wr(`CSSAC_ADDR_CTL, 8'h21);
    waitOn(2, 1'b0, "core");
    @(posedge clock);
    busPowerPin <= 1'b1;
    waitOn(2, 1'b1, "core");
    end_sim;
  end
endmodule
